// ===== verification/power_alarm_ringing_param_ram_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module power_alarm_ringing_param_ram_tb;
  // =====================================================================
  // signals
  logic sys_clk, sys_rst, ram_chan, ram_we, ram_re, ram_rvalid;
  logic linefeed_integrated, cmp_strobe;
  logic [7:0] ram_addr;
  logic [15:0] ram_wdata, ram_rdata;
  logic [1:0][15:0] pair1_power, pair2_power, pair3_power, total_power;
  logic [1:0][15:0] pair3_base_res, ring_peak_amp;
  logic [1:0][2:0] power_alarm;
  logic [1:0] ring_mode;
  logic [1:0][27:0] ring_freq_coef;
  logic [1:0][14:0] ring_offset_applied;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] addrs [9] = '{8'h25, 8'h26, 8'h27, 8'h2b, 8'h32, 8'h38, 8'h39, 8'h3a, 8'h3b};

  power_alarm_ringing_param_ram i_dut (
    .sys_clk, .sys_rst, .ram_chan, .ram_addr, .ram_wdata, .ram_we, .ram_re,
    .ram_rdata, .ram_rvalid, .linefeed_integrated, .cmp_strobe, .pair1_power,
    .pair2_power, .pair3_power, .total_power, .power_alarm, .pair3_base_res,
    .ring_mode, .ring_peak_amp, .ring_freq_coef, .ring_offset_applied
  );

  // =====================================================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("[FAIL] run did not finish within the cycle ceiling");
      final_report();
    end
  end

  // =====================================================================
  // access tasks, all entered and left on a falling edge
  function automatic logic [15:0] msk(input logic [7:0] a);
    msk = (a == 8'h38 || a == 8'h39) ? 16'h7fff : (a == 8'h3a) ? 16'hfff8 : 16'hffff;
  endfunction : msk

  task automatic wr(input logic ch, input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    ram_chan = ch;
    ram_addr = a;
    ram_wdata = d;
    ram_we = 1'b1;
    @(negedge sys_clk);
    ram_we = 1'b0;
  endtask : wr

  task automatic rd(input logic ch, input logic [7:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    ram_chan = ch;
    ram_addr = a;
    ram_re = 1'b1;
    @(negedge sys_clk);
    // read valid stands for one cycle only, so look while it is up
    `CHK("read valid", 1'b1, ram_rvalid)
    `CHK("read data", e, ram_rdata)
    ram_re = 1'b0;
  endtask : rd

  // write, then read the same word on the very next edge
  task automatic wr_rd(input logic ch, input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    ram_chan = ch;
    ram_addr = a;
    ram_wdata = d;
    ram_we = 1'b1;
    @(negedge sys_clk);
    ram_we = 1'b0;
    ram_re = 1'b1;
    @(negedge sys_clk);
    `CHK("back to back valid", 1'b1, ram_rvalid)
    `CHK("back to back data", d & msk(a), ram_rdata)
    ram_re = 1'b0;
  endtask : wr_rd

  // comparison cycle, then the total-power word read on the next edge
  task automatic strobe_rd(input logic ch, input logic [15:0] e);
    @(negedge sys_clk);
    ram_chan = ch;
    cmp_strobe = 1'b1;
    @(negedge sys_clk);
    cmp_strobe = 1'b0;
    ram_addr = 8'h32;
    ram_re = 1'b1;
    @(negedge sys_clk);
    `CHK("total after strobe", e, ram_rdata)
    ram_re = 1'b0;
  endtask : strobe_rd

  // alarms are looked at one edge after the strobe edge
  task automatic strobe();
    @(negedge sys_clk);
    cmp_strobe = 1'b1;
    @(negedge sys_clk);
    cmp_strobe = 1'b0;
  endtask : strobe

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // =====================================================================
  // tests
  initial begin
    {ram_chan, ram_we, ram_re, linefeed_integrated, cmp_strobe} = '0;
    {ram_addr, ram_wdata, ring_mode} = '0;
    {pair1_power, pair2_power, pair3_power, total_power} = '0;
    sys_rst = 1'b1;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    foreach (addrs[i]) for (int c = 0; c < 2; c++) rd(c[0], addrs[i], 16'h0000);
    $display("test reset values done");
    // channel 1 gets address-tagged data so a crossed channel or address shows
    foreach (addrs[i]) begin
      wr(1'b0, addrs[i], 16'hffff);
      wr(1'b1, addrs[i], {8'h5a, addrs[i]});
    end
    wr(1'b0, 8'h30, 16'hbeef);
    foreach (addrs[i]) begin
      rd(1'b0, addrs[i], (addrs[i] == 8'h32) ? 16'h0000 : msk(addrs[i]));
      rd(1'b1, addrs[i], (addrs[i] == 8'h32) ? 16'h0000 : msk(addrs[i]) & {8'h5a, addrs[i]});
    end
    rd(1'b0, 8'h30, 16'h0000);
    $display("test write and read back done");
    `CHK("base resistance", 16'h5a2b, pair3_base_res[1])
    `CHK("peak amplitude", 16'hffff, ring_peak_amp[0])
    `CHK("peak amplitude", 16'h5a3b, ring_peak_amp[1])
    `CHK("freq coef", 28'hfffffff, ring_freq_coef[0])
    `CHK("freq coef", {15'h5a39, 13'h0b47}, ring_freq_coef[1])
    `CHK("offset idle", 15'h0000, ring_offset_applied[1])
    ring_mode = 2'b10;
    repeat (2) @(negedge sys_clk);
    `CHK("offset ringing", 15'h5a38, ring_offset_applied[1])
    `CHK("offset other chan", 15'h0000, ring_offset_applied[0])
    $display("test parameter outputs done");
    // equal power reaches the threshold, one below does not
    pair1_power = {16'h5a25, 16'hffff};
    pair2_power = {16'h5a25, 16'hfffe};
    pair3_power = {16'h5a28, 16'h0000};
    total_power = {16'h5a24, 16'h0abc};
    strobe();
    `CHK("alarms chan0", 3'b001, power_alarm[0])
    `CHK("alarms chan1", 3'b101, power_alarm[1])
    rd(1'b0, 8'h32, 16'h0abc);
    rd(1'b1, 8'h32, 16'h5a24);
    linefeed_integrated = 1'b1;
    pair3_power = '0;
    repeat (3) @(negedge sys_clk);
    `CHK("alarms held", 3'b101, power_alarm[1])
    pair3_power = {16'h5a28, 16'h0000};
    strobe();
    `CHK("integrated chan0", 3'b000, power_alarm[0])
    `CHK("integrated chan1", 3'b100, power_alarm[1])
    total_power = {16'h5a25, 16'h0abc};
    wr(1'b1, 8'h26, 16'h0001);
    strobe();
    `CHK("new threshold", 3'b111, power_alarm[1])
    $display("test alarms done");
    wr_rd(1'b1, 8'h27, 16'h00ff);
    wr_rd(1'b0, 8'h3a, 16'h1237);
    total_power = {16'h5a25, 16'hffff};
    strobe_rd(1'b0, 16'hffff);
    `CHK("integrated total chan0", 3'b001, power_alarm[0])
    $display("test back to back access done");
    final_report();
  end
endmodule : power_alarm_ringing_param_ram_tb

// ===== verilog/alarm_cmp_if.sv
`timescale 1ns/1ps
interface alarm_cmp_if;
  logic strobe;
  logic integrated;
  logic [15:0] thr1;
  logic [15:0] thr2;
  logic [15:0] thr3;
  logic [15:0] pwr1;
  logic [15:0] pwr2;
  logic [15:0] pwr3;
  logic [15:0] total;
  logic [2:0] alarm;

  modport owner (
    output strobe, integrated, thr1, thr2, thr3, pwr1, pwr2, pwr3, total,
    input alarm
  );
  modport cmp (
    input strobe, integrated, thr1, thr2, thr3, pwr1, pwr2, pwr3, total,
    output alarm
  );
endinterface : alarm_cmp_if

// ===== verilog/power_alarm_compare.sv
`timescale 1ns/1ps
module power_alarm_compare (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // thresholds, powers and alarms
  alarm_cmp_if.cmp port
);
  logic [2:0] next_alarm;

  // =====================================================================
  // comparison
  // integrated linefeed turns pair 1's threshold into the total-power limit
  assign next_alarm[0] = port.integrated ? (port.total >= port.thr1) :
                                           (port.pwr1 >= port.thr1);
  assign next_alarm[1] = port.pwr2 >= port.thr2;
  assign next_alarm[2] = port.pwr3 >= port.thr3;

  // alarms only move on a comparison cycle; in between they hold
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      port.alarm <= 3'h0;
    end else if (port.strobe) begin
      port.alarm <= next_alarm;
    end
  end
endmodule : power_alarm_compare

// ===== verilog/power_alarm_ringing_param_ram.sv
// Operation
// - pair 1 raises its alarm when its computed power reaches its threshold at 498 uW/LSB.
// - in integrated linefeed mode the pair 1 threshold limits total power at 1059.6 uW/LSB.
// - pair 2 raises its alarm when its computed power reaches its threshold at 31.4 uW/LSB.
// - pair 3 raises its alarm when its computed power reaches its threshold at 498 uW/LSB.
// - the three thresholds are 16-bit read/write words at ram addresses 37, 38 and 39.
// - ram address 43 holds the 16-bit pair 3 base resistance used by the power calculation.
// - ram address 59 holds the 16-bit peak ringing amplitude, readable and writable.
// - bits 14:0 of ram address 57 form the upper part of the ringing frequency coefficient.
// - bits 15:3 of ram address 58 form the lower part, and bits 2:0 hold nothing.
// - bits 14:0 of ram address 56 are added as dc offset only while ringing, 4.907 mV/LSB.
// - the total computed power of all six transistors reads back as a 16-bit word.
`timescale 1ns/1ps
module power_alarm_ringing_param_ram (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ram access from the serial control port
  input wire logic ram_chan,
  input wire logic [7:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [15:0] ram_rdata,
  output logic ram_rvalid,
  // power calculation side
  input wire logic linefeed_integrated,
  input wire logic cmp_strobe,
  input wire logic [1:0][15:0] pair1_power,
  input wire logic [1:0][15:0] pair2_power,
  input wire logic [1:0][15:0] pair3_power,
  input wire logic [1:0][15:0] total_power,
  output logic [1:0][2:0] power_alarm,
  output logic [1:0][15:0] pair3_base_res,
  // ringing generator side
  input wire logic [1:0] ring_mode,
  output logic [1:0][15:0] ring_peak_amp,
  output logic [1:0][27:0] ring_freq_coef,
  output logic [1:0][14:0] ring_offset_applied
);
  // =====================================================================
  // storage
  logic [15:0] params [power_ram_pkg::CHANNELS][power_ram_pkg::SLOTS];
  logic [1:0][15:0] ring_peak_amplitude;
  logic [1:0][15:0] total_computed_power;

  // =====================================================================
  // decode
  wire [2:0] wr_slot = power_ram_pkg::slot_of(ram_addr);
  wire [15:0] wr_mask = power_ram_pkg::field_mask(ram_addr);
  wire wr_slot_hit = ram_we && (wr_slot != 3'h7);
  wire wr_amp_hit = ram_we && (ram_addr == power_ram_pkg::ADDR_RING_PEAK_AMP);
  wire rd_total = ram_addr == power_ram_pkg::ADDR_TOTAL_POWER;
  wire rd_amp = ram_addr == power_ram_pkg::ADDR_RING_PEAK_AMP;
  // slot code 7 names no word; keep the read index inside the array
  wire [2:0] rd_slot = (wr_slot == 3'h7) ? power_ram_pkg::SLOT_PAIR1_THR : wr_slot;
  wire [15:0] rd_slot_data = params[ram_chan][rd_slot] & wr_mask;
  // unmapped addresses read as zero; the total-power word ignores writes
  wire [15:0] next_rdata = rd_total ? total_computed_power[ram_chan] :
                           rd_amp ? ring_peak_amplitude[ram_chan] :
                           (wr_slot != 3'h7) ? rd_slot_data : 16'h0000;

  // =====================================================================
  // ram writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int c = 0; c < power_ram_pkg::CHANNELS; c++) begin
        for (int s = 0; s < power_ram_pkg::SLOTS; s++) begin
          params[c][s] <= power_ram_pkg::RESET_VALUE;
        end
      end
    end else if (wr_slot_hit) begin
      params[ram_chan][wr_slot] <= ram_wdata & wr_mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ring_peak_amplitude <= {2{power_ram_pkg::RESET_VALUE}};
    end else if (wr_amp_hit) begin
      ring_peak_amplitude[ram_chan] <= ram_wdata;
    end
  end

  // total power is captured on the same comparison cycle that drives the alarms
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      total_computed_power <= {2{power_ram_pkg::RESET_VALUE}};
    end else if (cmp_strobe) begin
      total_computed_power <= total_power;
    end
  end

  // =====================================================================
  // ram reads: data one cycle after the request, old data on a same-cycle write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ram_rdata <= 16'h0000;
      ram_rvalid <= 1'b0;
    end else begin
      ram_rvalid <= ram_re;
      if (ram_re) begin
        ram_rdata <= next_rdata;
      end
    end
  end

  // =====================================================================
  // per-channel parameter outputs, registered so each port leaves a flop
  for (genvar ch = 0; ch < power_ram_pkg::CHANNELS; ch++) begin : g_chan
    alarm_cmp_if cmp_bus ();

    assign cmp_bus.strobe = cmp_strobe;
    assign cmp_bus.integrated = linefeed_integrated;
    assign cmp_bus.thr1 = params[ch][power_ram_pkg::SLOT_PAIR1_THR];
    assign cmp_bus.thr2 = params[ch][power_ram_pkg::SLOT_PAIR2_THR];
    assign cmp_bus.thr3 = params[ch][power_ram_pkg::SLOT_PAIR3_THR];
    assign cmp_bus.pwr1 = pair1_power[ch];
    assign cmp_bus.pwr2 = pair2_power[ch];
    assign cmp_bus.pwr3 = pair3_power[ch];
    assign cmp_bus.total = total_power[ch];
    assign power_alarm[ch] = cmp_bus.alarm;

    power_alarm_compare u_cmp (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .port(cmp_bus)
    );

    wire [14:0] freq_upper = params[ch][power_ram_pkg::SLOT_FREQ_UPPER]
                             [power_ram_pkg::FREQ_UPPER_MSB:0];
    wire [12:0] freq_lower = params[ch][power_ram_pkg::SLOT_FREQ_LOWER]
                             [power_ram_pkg::FREQ_LOWER_MSB:power_ram_pkg::FREQ_LOWER_LSB];
    wire [14:0] dc_offset = params[ch][power_ram_pkg::SLOT_DC_OFFSET]
                            [power_ram_pkg::OFFSET_MSB:0];

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        pair3_base_res[ch] <= 16'h0000;
        ring_peak_amp[ch] <= 16'h0000;
        ring_freq_coef[ch] <= 28'h0000000;
        ring_offset_applied[ch] <= 15'h0000;
      end else begin
        pair3_base_res[ch] <= params[ch][power_ram_pkg::SLOT_BASE_RES];
        ring_peak_amp[ch] <= ring_peak_amplitude[ch];
        ring_freq_coef[ch] <= {freq_upper, freq_lower};
        // offset only reaches the waveform while the line is ringing
        ring_offset_applied[ch] <= ring_mode[ch] ? dc_offset : 15'h0000;
      end
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_pair1_alarm: assert property (cmp_strobe && !linefeed_integrated |=>
    power_alarm[0][0] == ($past(pair1_power[0]) >= $past(params[0][0])))
    else $error("pair 1 alarm does not follow its threshold");
  a_total_alarm: assert property (cmp_strobe && linefeed_integrated |=>
    power_alarm[1][0] == ($past(total_power[1]) >= $past(params[1][0])))
    else $error("total power alarm does not follow pair 1 threshold");
  a_pair2_alarm: assert property (cmp_strobe |=>
    power_alarm[0][1] == ($past(pair2_power[0]) >= $past(params[0][1])))
    else $error("pair 2 alarm does not follow its threshold");
  a_pair3_alarm: assert property (cmp_strobe |=>
    power_alarm[1][2] == ($past(pair3_power[1]) >= $past(params[1][2])))
    else $error("pair 3 alarm does not follow its threshold");
  a_alarm_hold: assert property (!cmp_strobe |=> $stable(power_alarm))
    else $error("alarm moved outside a comparison cycle");
  a_thr_readback: assert property ((ram_we && !ram_re &&
    ram_addr == power_ram_pkg::ADDR_PAIR3_THR) ##1 (ram_re && !ram_we &&
    ram_addr == power_ram_pkg::ADDR_PAIR3_THR && ram_chan == $past(ram_chan))
    |=> ram_rvalid && ram_rdata == $past(ram_wdata, 2))
    else $error("threshold read back differs from write");
  a_base_res_out: assert property (ram_we && !ram_chan &&
    ram_addr == power_ram_pkg::ADDR_PAIR3_BASE_RES |=> ##1
    pair3_base_res[0] == $past(ram_wdata, 2))
    else $error("base resistance output missed a write");
  a_amp_out: assert property (ram_we && ram_chan &&
    ram_addr == power_ram_pkg::ADDR_RING_PEAK_AMP |=> ##1
    ring_peak_amp[1] == $past(ram_wdata, 2))
    else $error("ringing amplitude output missed a write");
  a_freq_upper: assert property (ram_we && !ram_chan &&
    ram_addr == power_ram_pkg::ADDR_RING_FREQ_UPPER |=> ##1
    ring_freq_coef[0][27:13] == $past(ram_wdata[14:0], 2))
    else $error("frequency upper part wrong");
  a_freq_lower: assert property (ram_re &&
    ram_addr == power_ram_pkg::ADDR_RING_FREQ_LOWER |=> ram_rdata[2:0] == 3'h0)
    else $error("frequency lower unused bits not zero");
  a_offset_gate: assert property (!ring_mode[0] |=> ring_offset_applied[0] == 15'h0000)
    else $error("dc offset applied outside ringing");
  a_total_read: assert property ((cmp_strobe && !ram_chan) ##1 (ram_re && !cmp_strobe &&
    !ram_chan && ram_addr == power_ram_pkg::ADDR_TOTAL_POWER) |=>
    ram_rdata == $past(total_power[0], 2))
    else $error("total power read back wrong");

  // the other channel of the pair 2 and pair 3 comparisons, so a crossed channel shows
  a_pair2_chan1: assert property (cmp_strobe |=>
    power_alarm[1][1] == ($past(pair2_power[1]) >= $past(params[1][1])))
    else $error("pair 2 alarm of channel 1 does not follow its threshold");
  a_pair3_chan0: assert property (cmp_strobe |=>
    power_alarm[0][2] == ($past(pair3_power[0]) >= $past(params[0][2])))
    else $error("pair 3 alarm of channel 0 does not follow its threshold");
  a_rvalid_pulse: assert property (ram_re |=> ram_rvalid)
    else $error("read valid missing after a read");
  a_rvalid_idle: assert property (!ram_re |=> !ram_rvalid)
    else $error("read valid without a read");
  a_total_readonly: assert property (ram_we && !cmp_strobe &&
    ram_addr == power_ram_pkg::ADDR_TOTAL_POWER |=> $stable(total_computed_power))
    else $error("total power word changed by a write");
  a_offset_ringing: assert property (ring_mode[1] |=> ring_offset_applied[1] ==
    $past(params[1][power_ram_pkg::SLOT_DC_OFFSET][14:0]))
    else $error("dc offset not applied while ringing");

  c_alarm_raised: cover property (cmp_strobe ##1 power_alarm[0][1]);
  c_integrated_alarm: cover property (cmp_strobe && linefeed_integrated ##1 power_alarm[1][0]);
  c_ringing_offset: cover property (ring_mode[0] ##1 ring_offset_applied[0] != 15'h0000);
  c_write_then_read: cover property (ram_we ##1 ram_re ##1 ram_rvalid);
  c_total_after_strobe: cover property (cmp_strobe ##1
    (ram_re && ram_addr == power_ram_pkg::ADDR_TOTAL_POWER));
endmodule : power_alarm_ringing_param_ram

// ===== verilog/power_ram_pkg.sv
package power_ram_pkg;
  // =====================================================================
  // sizes
  localparam int CHANNELS = 2;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int SLOTS = 7;
  localparam int FREQ_COEF_W = 28;
  localparam int OFFSET_W = 15;

  // =====================================================================
  // ram addresses
  localparam logic [7:0] ADDR_PAIR1_THR = 8'h25;
  localparam logic [7:0] ADDR_PAIR2_THR = 8'h26;
  localparam logic [7:0] ADDR_PAIR3_THR = 8'h27;
  localparam logic [7:0] ADDR_PAIR3_BASE_RES = 8'h2b;
  localparam logic [7:0] ADDR_TOTAL_POWER = 8'h32;
  localparam logic [7:0] ADDR_RING_DC_OFFSET = 8'h38;
  localparam logic [7:0] ADDR_RING_FREQ_UPPER = 8'h39;
  localparam logic [7:0] ADDR_RING_FREQ_LOWER = 8'h3a;
  localparam logic [7:0] ADDR_RING_PEAK_AMP = 8'h3b;

  // =====================================================================
  // storage slots inside one channel
  localparam logic [2:0] SLOT_PAIR1_THR = 3'h0;
  localparam logic [2:0] SLOT_PAIR2_THR = 3'h1;
  localparam logic [2:0] SLOT_PAIR3_THR = 3'h2;
  localparam logic [2:0] SLOT_BASE_RES = 3'h3;
  localparam logic [2:0] SLOT_DC_OFFSET = 3'h4;
  localparam logic [2:0] SLOT_FREQ_UPPER = 3'h5;
  localparam logic [2:0] SLOT_FREQ_LOWER = 3'h6;

  // =====================================================================
  // fields, masks and reset value
  localparam logic [15:0] MASK_FULL = 16'hffff;
  localparam logic [15:0] MASK_LOW15 = 16'h7fff;
  localparam logic [15:0] MASK_FREQ_LOWER = 16'hfff8;
  localparam int FREQ_UPPER_MSB = 14;
  localparam int FREQ_LOWER_MSB = 15;
  localparam int FREQ_LOWER_LSB = 3;
  localparam int OFFSET_MSB = 14;
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // bits that hold no field read back as zero
  function automatic logic [15:0] field_mask(input logic [7:0] addr);
    case (addr)
      ADDR_RING_DC_OFFSET, ADDR_RING_FREQ_UPPER: field_mask = MASK_LOW15;
      ADDR_RING_FREQ_LOWER: field_mask = MASK_FREQ_LOWER;
      default: field_mask = MASK_FULL;
    endcase
  endfunction : field_mask

  // ring peak amplitude lives outside the slot array since it has its own port
  function automatic logic [2:0] slot_of(input logic [7:0] addr);
    case (addr)
      ADDR_PAIR1_THR: slot_of = SLOT_PAIR1_THR;
      ADDR_PAIR2_THR: slot_of = SLOT_PAIR2_THR;
      ADDR_PAIR3_THR: slot_of = SLOT_PAIR3_THR;
      ADDR_PAIR3_BASE_RES: slot_of = SLOT_BASE_RES;
      ADDR_RING_DC_OFFSET: slot_of = SLOT_DC_OFFSET;
      ADDR_RING_FREQ_UPPER: slot_of = SLOT_FREQ_UPPER;
      ADDR_RING_FREQ_LOWER: slot_of = SLOT_FREQ_LOWER;
      default: slot_of = 3'h7;
    endcase
  endfunction : slot_of
endpackage : power_ram_pkg
